// [src/startup_cfg_pkg.sv]
// constants, register map and state encoding of the development-mode start-up loader
// Behaviour
// - start each supply in its programmed slot; a zero slot never auto-starts.
// - hold the power-up sequence until configuration-done is written with one.
// - alternate-pin select written zero routes accesses to the primary interface.
// - the device-address field sets our own primary interface address.
// - after start-up, slot and reset-duration writes have no effect.
// - four converter and four regulator level fields, regulator ones five bits, are applied at start-up.
// - per-pin pull, debounce, function, direction, polarity plus shared debounce time.
// - reset output pulse length comes from the reset-duration field.
// - address field 00/01/10/11 gives 0x34/0x36/0x3C/0x3E.
// - configuration-done missing at set-up timeout returns the device to off.
// - drive the pre-start indication high when about to start up.
package startup_cfg_pkg;
  localparam int NREG = 32;
  localparam int NSUP = 11;
  localparam int NGPIO = 13;
  // register offsets, position in this table is the storage index
  localparam logic [7:0] OFS_TABLE [NREG] = '{
    8'h03, 8'h06, 8'h80, 8'h81, 8'h82, 8'h86, 8'h87, 8'h8C, 8'h8D, 8'h8E, 8'h8F,
    8'hA8, 8'hB4, 8'hB5, 8'hB7, 8'hBA, 8'hBB, 8'hBD, 8'hBE, 8'hC1, 8'hC3, 8'hC4,
    8'hC7, 8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCE, 8'hCF, 8'hD1, 8'hD2, 8'hDB};
  localparam logic [4:0] IDX_RST_DUR = 5'h00;
  localparam logic [4:0] IDX_IFC = 5'h01;
  localparam logic [4:0] IDX_DEBOUNCE = 5'h02;
  localparam logic [4:0] IDX_PULLUP = 5'h03;
  localparam logic [4:0] IDX_PULLDOWN = 5'h04;
  localparam logic [4:0] IDX_DIR = 5'h05;
  localparam logic [4:0] IDX_POL = 5'h06;
  localparam logic [4:0] IDX_FN0 = 5'h07;
  localparam logic [4:0] IDX_FN1 = 5'h08;
  localparam logic [4:0] IDX_FN2 = 5'h09;
  localparam logic [4:0] IDX_FN3 = 5'h0A;
  // supplies: converters 1..6, regulators 1..4, limit switch
  localparam logic [4:0] SLOT_IDX [NSUP] = '{5'h0D, 5'h0E, 5'h10, 5'h12, 5'h13, 5'h15,
                                             5'h18, 5'h1A, 5'h1C, 5'h1E, 5'h16};
  localparam logic [4:0] CONV_LVL_IDX [4] = '{5'h0C, 5'h0F, 5'h11, 5'h14};
  localparam logic [4:0] REG_LVL_IDX [4] = '{5'h17, 5'h19, 5'h1B, 5'h1D};
  // interface control field layout
  localparam int IFC_ALT_BIT = 15;
  localparam int IFC_ADDR_LSB = 13;
  localparam int IFC_DONE_BIT = 12;
  localparam int IFC_RECONFIG_BIT = 11;
  localparam logic [15:0] IFC_RESET = 16'h8800;
  localparam int SLOT_LSB = 10;
  localparam int DBTIME_LSB = 13;
  localparam logic [3:0] SLOT_LAST = 4'hF;
  localparam logic [3:0] SLOT_NONE = 4'h0;
  // primary interface addresses, seven-bit form
  localparam logic [6:0] PADDR_00 = 7'h1A;
  localparam logic [6:0] PADDR_01 = 7'h1B;
  localparam logic [6:0] PADDR_10 = 7'h1E;
  localparam logic [6:0] PADDR_11 = 7'h1F;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SLOT_TIME_NS = 1280000;
  localparam int SETUP_TIME_NS = 500000000;
  localparam int RST_UNIT_NS = 1000000;
  localparam int SLOT_CYC = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam int SETUP_CYC = SETUP_TIME_NS / CLK_PERIOD_NS;
  localparam int RST_UNIT_CYC = (RST_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // power states, gray along off-prestart-sequence-reset-active
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_PRE = 3'h1,
    ST_SEQ = 3'h3,
    ST_RST = 3'h2,
    ST_ACT = 3'h6
  } pstate_t;
endpackage : startup_cfg_pkg

// [src/dev_mode_startup_config.sv]
// development-mode start-up configuration store and power-up sequencer
`timescale 1ns/10ps
`default_nettype none
module dev_mode_startup_config #(
  parameter int SLOT_CYCLES = startup_cfg_pkg::SLOT_CYC,
  parameter int SETUP_CYCLES = startup_cfg_pkg::SETUP_CYC,
  parameter int RST_UNIT_CYCLES = startup_cfg_pkg::RST_UNIT_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic power_on_req_i,
  input wire logic acc_i,
  input wire logic acc_wr_i,
  input wire logic from_primary_i,
  input wire logic [6:0] primary_addr_select_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic acc_ack_o,
  output logic [15:0] reg_rdata_o,
  output logic prestart_indication_o,
  output logic reset_n_o,
  output logic [2:0] power_state_o,
  output logic [10:0] supply_en_o,
  output logic [27:0] converter_level_o,
  output logic [19:0] regulator_level_o,
  output logic [6:0] primary_addr_o,
  output logic alt_pin_select_o,
  output logic [51:0] pin_function_o,
  output logic [12:0] pin_direction_o,
  output logic [12:0] pin_polarity_o,
  output logic [12:0] pin_pullup_o,
  output logic [12:0] pin_pulldown_o,
  output logic [12:0] pin_debounce_on_o,
  output logic [2:0] debounce_period_o
);

  // timer counts are compared on 32 bits, so keep them positive and representable
  generate
    if (SLOT_CYCLES < 1 || SETUP_CYCLES < 1 || RST_UNIT_CYCLES < 1) begin : g_bad_timing
      $error("timing counts must be at least one cycle");
    end
  endgenerate

  typedef struct packed {
    startup_cfg_pkg::pstate_t st;
    logic [31:0] tmr;
    logic [3:0] slot;
    logic [15:0] units;
    logic [startup_cfg_pkg::NREG-1:0][15:0] cfg;
    logic [10:0] sup_en;
    logic [3:0][6:0] conv_lvl;
    logic [3:0][4:0] reg_lvl;
    logic [6:0] paddr;
    logic alt;
    logic prestart;
    logic rst_out_n;
    logic ack;
    logic [15:0] rdata;
  } state_t;

  // register storage after power-on or an off entry with reconfiguration
  function automatic logic [startup_cfg_pkg::NREG-1:0][15:0] cfg_defaults();
    logic [startup_cfg_pkg::NREG-1:0][15:0] c;
    c = '0;
    c[startup_cfg_pkg::IDX_IFC] = startup_cfg_pkg::IFC_RESET;
    return c;
  endfunction : cfg_defaults

  // returns {hit, index} for a register offset
  function automatic logic [5:0] find_reg(input logic [7:0] a);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < startup_cfg_pkg::NREG; i++) begin
      if (startup_cfg_pkg::OFS_TABLE[i] == a) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction : find_reg

  // slot fields and the reset duration freeze once the sequence has begun
  function automatic logic frozen_reg(input logic [4:0] idx);
    logic f;
    f = (idx == startup_cfg_pkg::IDX_RST_DUR);
    for (int i = 0; i < startup_cfg_pkg::NSUP; i++) begin
      if (startup_cfg_pkg::SLOT_IDX[i] == idx) begin
        f = 1'b1;
      end
    end
    return f;
  endfunction : frozen_reg

  function automatic logic [3:0] slot_of(input logic [15:0] w);
    return w[startup_cfg_pkg::SLOT_LSB +: 4];
  endfunction : slot_of

  function automatic logic [6:0] addr_decode(input logic [1:0] sel);
    logic [6:0] a;
    case (sel)
      2'h0: a = startup_cfg_pkg::PADDR_00;
      2'h1: a = startup_cfg_pkg::PADDR_01;
      2'h2: a = startup_cfg_pkg::PADDR_10;
      default: a = startup_cfg_pkg::PADDR_11;
    endcase
    return a;
  endfunction : addr_decode

  localparam state_t Q_RST = '{
    st: startup_cfg_pkg::ST_OFF,
    tmr: 32'h0000_0000,
    slot: 4'h0,
    units: 16'h0000,
    cfg: cfg_defaults(),
    sup_en: 11'h000,
    conv_lvl: '0,
    reg_lvl: '0,
    paddr: startup_cfg_pkg::PADDR_00,
    alt: 1'b1,
    prestart: 1'b0,
    rst_out_n: 1'b0,
    ack: 1'b0,
    rdata: 16'h0000
  };

  state_t q;
  state_t d;
  logic acc_ok;
  logic hit;
  logic [4:0] idx;
  logic wr_ok;
  logic go_off;
  logic [10:0] zero_slot;
  logic ifc_wr;
  logic done_wr;

  // access decode: right pins for the routing and our own address
  always_comb begin
    {hit, idx} = find_reg(reg_addr_i);
    acc_ok = acc_i && (primary_addr_select_i == q.paddr) && (from_primary_i != q.alt);
    wr_ok = acc_ok && acc_wr_i && hit &&
            !(frozen_reg(idx) && q.st != startup_cfg_pkg::ST_OFF && q.st != startup_cfg_pkg::ST_PRE);
  end

  // which supplies have a slot of none, used by the checks below
  always_comb begin
    for (int i = 0; i < startup_cfg_pkg::NSUP; i++) begin
      zero_slot[i] = (slot_of(q.cfg[startup_cfg_pkg::SLOT_IDX[i]]) == startup_cfg_pkg::SLOT_NONE);
    end
  end

  // interface control writes, shared by the sequencer checks; plain booleans keep the checks tool-friendly
  always_comb begin
    ifc_wr = wr_ok && (idx == startup_cfg_pkg::IDX_IFC);
    done_wr = ifc_wr && reg_wdata_i[startup_cfg_pkg::IFC_DONE_BIT];
  end

  // next-state logic of the whole block
  always_comb begin
    d = q;
    d.ack = acc_ok;
    go_off = 1'b0;
    if (acc_ok && !acc_wr_i) begin
      d.rdata = hit ? q.cfg[idx] : 16'h0000;
    end
    if (wr_ok) begin
      d.cfg[idx] = reg_wdata_i;
    end
    // routing and address follow the stored field at the same edge that stores the write
    d.alt = d.cfg[startup_cfg_pkg::IDX_IFC][startup_cfg_pkg::IFC_ALT_BIT];
    d.paddr = addr_decode(d.cfg[startup_cfg_pkg::IDX_IFC][startup_cfg_pkg::IFC_ADDR_LSB +: 2]);
    if (q.st != startup_cfg_pkg::ST_OFF && !power_on_req_i) begin
      go_off = 1'b1;
    end
    case (q.st)
      startup_cfg_pkg::ST_OFF: begin
        d.sup_en = '0;
        d.rst_out_n = 1'b0;
        d.prestart = 1'b0;
        if (power_on_req_i) begin
          d.st = startup_cfg_pkg::ST_PRE;
          d.tmr = '0;
          d.prestart = 1'b1;
        end
      end
      startup_cfg_pkg::ST_PRE: begin
        d.tmr = q.tmr + 32'h0000_0001;
        if (d.cfg[startup_cfg_pkg::IDX_IFC][startup_cfg_pkg::IFC_DONE_BIT]) begin
          d.st = startup_cfg_pkg::ST_SEQ;
          d.tmr = '0;
          d.slot = 4'h1;
          // levels are latched here so later writes do not move a running supply
          for (int i = 0; i < 4; i++) begin
            d.conv_lvl[i] = d.cfg[startup_cfg_pkg::CONV_LVL_IDX[i]][6:0];
            d.reg_lvl[i] = d.cfg[startup_cfg_pkg::REG_LVL_IDX[i]][4:0];
          end
        end else if (q.tmr == 32'(SETUP_CYCLES - 1)) begin
          go_off = 1'b1;
        end
      end
      startup_cfg_pkg::ST_SEQ: begin
        for (int i = 0; i < startup_cfg_pkg::NSUP; i++) begin
          if (slot_of(q.cfg[startup_cfg_pkg::SLOT_IDX[i]]) == q.slot && q.slot != startup_cfg_pkg::SLOT_NONE) begin
            d.sup_en[i] = 1'b1;
          end
        end
        d.tmr = q.tmr + 32'h0000_0001;
        if (q.tmr == 32'(SLOT_CYCLES - 1)) begin
          d.tmr = '0;
          if (q.slot == startup_cfg_pkg::SLOT_LAST) begin
            d.st = startup_cfg_pkg::ST_RST;
            d.units = q.cfg[startup_cfg_pkg::IDX_RST_DUR];
          end else begin
            d.slot = q.slot + 4'h1;
          end
        end
      end
      startup_cfg_pkg::ST_RST: begin
        d.rst_out_n = 1'b0;
        d.tmr = q.tmr + 32'h0000_0001;
        if (q.tmr == 32'(RST_UNIT_CYCLES - 1)) begin
          d.tmr = '0;
          if (q.units == 16'h0000) begin
            d.st = startup_cfg_pkg::ST_ACT;
            d.rst_out_n = 1'b1;
          end else begin
            d.units = q.units - 16'h0001;
          end
        end
      end
      startup_cfg_pkg::ST_ACT: begin
        d.rst_out_n = 1'b1;
      end
      default: begin
        go_off = 1'b1;
      end
    endcase
    // off entry: registers reload unless reconfiguration is switched off
    if (go_off) begin
      d.st = startup_cfg_pkg::ST_OFF;
      d.sup_en = '0;
      d.rst_out_n = 1'b0;
      d.prestart = 1'b0;
      d.tmr = '0;
      if (q.cfg[startup_cfg_pkg::IDX_IFC][startup_cfg_pkg::IFC_RECONFIG_BIT]) begin
        d.cfg = cfg_defaults();
      end else begin
        d.cfg[startup_cfg_pkg::IDX_IFC][startup_cfg_pkg::IFC_DONE_BIT] = 1'b0;
      end
      d.alt = d.cfg[startup_cfg_pkg::IDX_IFC][startup_cfg_pkg::IFC_ALT_BIT];
      d.paddr = addr_decode(d.cfg[startup_cfg_pkg::IDX_IFC][startup_cfg_pkg::IFC_ADDR_LSB +: 2]);
    end
  end

  // single state register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      q <= Q_RST;
    end else begin
      q <= d;
    end
  end

  // outputs are taken straight from the state register
  assign acc_ack_o = q.ack;
  assign reg_rdata_o = q.rdata;
  assign prestart_indication_o = q.prestart;
  assign reset_n_o = q.rst_out_n;
  assign power_state_o = q.st;
  assign supply_en_o = q.sup_en;
  assign converter_level_o = q.conv_lvl;
  assign regulator_level_o = q.reg_lvl;
  assign primary_addr_o = q.paddr;
  assign alt_pin_select_o = q.alt;
  assign pin_function_o = {q.cfg[startup_cfg_pkg::IDX_FN3][3:0], q.cfg[startup_cfg_pkg::IDX_FN2],
                           q.cfg[startup_cfg_pkg::IDX_FN1], q.cfg[startup_cfg_pkg::IDX_FN0]};
  assign pin_direction_o = q.cfg[startup_cfg_pkg::IDX_DIR][12:0];
  assign pin_polarity_o = q.cfg[startup_cfg_pkg::IDX_POL][12:0];
  assign pin_pullup_o = q.cfg[startup_cfg_pkg::IDX_PULLUP][12:0];
  assign pin_pulldown_o = q.cfg[startup_cfg_pkg::IDX_PULLDOWN][12:0];
  assign pin_debounce_on_o = q.cfg[startup_cfg_pkg::IDX_DEBOUNCE][12:0];
  assign debounce_period_o = q.cfg[startup_cfg_pkg::IDX_DEBOUNCE][startup_cfg_pkg::DBTIME_LSB +: 3];

  // checks on the sequencer
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_ifc_write;
    ifc_wr;
  endsequence

  sequence s_done_write;
    q.st == startup_cfg_pkg::ST_PRE && done_wr;
  endsequence

  property p_no_zero_slot;
    (supply_en_o & zero_slot) == 11'h000;
  endproperty
  a_no_zero_slot: assert property (p_no_zero_slot) else $error("supply with empty slot enabled");

  property p_slot_start;
    (q.st == startup_cfg_pkg::ST_SEQ && q.slot != 4'h0 && power_on_req_i &&
     slot_of(q.cfg[startup_cfg_pkg::SLOT_IDX[0]]) == q.slot) |=> supply_en_o[0];
  endproperty
  a_slot_start: assert property (p_slot_start) else $error("converter not started in its slot");

  property p_hold_off;
    q.st == startup_cfg_pkg::ST_PRE |-> supply_en_o == 11'h000 && !reset_n_o;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("supply started before configuration done");

  property p_done_starts;
    s_done_write ##0 power_on_req_i |=> q.st == startup_cfg_pkg::ST_SEQ && q.slot == 4'h1;
  endproperty
  a_done_starts: assert property (p_done_starts) else $error("done write did not start sequence");

  property p_alt_route;
    s_ifc_write ##0 !reg_wdata_i[startup_cfg_pkg::IFC_ALT_BIT] && power_on_req_i |=> !alt_pin_select_o;
  endproperty
  a_alt_route: assert property (p_alt_route) else $error("control not handed to primary pins");

  property p_addr;
    s_ifc_write ##0 power_on_req_i |=>
      primary_addr_o == addr_decode($past(reg_wdata_i[startup_cfg_pkg::IFC_ADDR_LSB +: 2]));
  endproperty
  a_addr: assert property (p_addr) else $error("primary address does not follow field");

  property p_timeout;
    (q.st == startup_cfg_pkg::ST_PRE && q.tmr == 32'(SETUP_CYCLES - 1) && !done_wr)
      |=> q.st == startup_cfg_pkg::ST_OFF && !prestart_indication_o;
  endproperty
  a_timeout: assert property (p_timeout) else $error("set-up timeout did not return to off");

  property p_prestart;
    (q.st == startup_cfg_pkg::ST_PRE || q.st == startup_cfg_pkg::ST_SEQ) |-> prestart_indication_o;
  endproperty
  a_prestart: assert property (p_prestart) else $error("pre-start indication low while starting");

  property p_prestart_rise;
    q.st == startup_cfg_pkg::ST_OFF && power_on_req_i |=> q.st == startup_cfg_pkg::ST_PRE && prestart_indication_o;
  endproperty
  a_prestart_rise: assert property (p_prestart_rise) else $error("pre-start not raised on request");

  property p_refuse_pins;
    acc_i && from_primary_i == alt_pin_select_o |=> !acc_ack_o;
  endproperty
  a_refuse_pins: assert property (p_refuse_pins) else $error("access on unselected pins acknowledged");

  property p_level_apply;
    (q.st == startup_cfg_pkg::ST_PRE ##1 q.st == startup_cfg_pkg::ST_SEQ)
      |-> converter_level_o[6:0] == q.cfg[startup_cfg_pkg::CONV_LVL_IDX[0]][6:0] &&
          regulator_level_o[4:0] == q.cfg[startup_cfg_pkg::REG_LVL_IDX[0]][4:0];
  endproperty
  a_level_apply: assert property (p_level_apply) else $error("levels not applied at start-up");

  property p_slot_frozen;
    (q.st == startup_cfg_pkg::ST_ACT && power_on_req_i && acc_ok && acc_wr_i && hit && frozen_reg(idx))
      |=> q.cfg == $past(q.cfg);
  endproperty
  a_slot_frozen: assert property (p_slot_frozen) else $error("slot write took effect after start-up");

  property p_rst_end;
    (q.st == startup_cfg_pkg::ST_RST && q.units == 16'h0000 && q.tmr == 32'(RST_UNIT_CYCLES - 1) &&
     power_on_req_i) |-> !reset_n_o ##1 reset_n_o && q.st == startup_cfg_pkg::ST_ACT;
  endproperty
  a_rst_end: assert property (p_rst_end) else $error("reset pulse length wrong");

  property p_gpio_write;
    (wr_ok && idx == startup_cfg_pkg::IDX_PULLUP && q.st != startup_cfg_pkg::ST_OFF && power_on_req_i)
      |=> pin_pullup_o == $past(reg_wdata_i[12:0]);
  endproperty
  a_gpio_write: assert property (p_gpio_write) else $error("pin pull-up setting not stored");

endmodule : dev_mode_startup_config
`default_nettype wire

// [bench/cfg_controller_model.sv]
// partner model: configuration controller on the secondary two-wire pins
`timescale 1ns/10ps
`default_nettype none
module cfg_controller_model (
  input wire logic clk_sys_i,
  input wire logic acc_ack_i,
  input wire logic [15:0] reg_rdata_i,
  output logic acc_o,
  output logic acc_wr_o,
  output logic from_primary_o,
  output logic [6:0] primary_addr_select_o,
  output logic [7:0] reg_addr_o,
  output logic [15:0] reg_wdata_o
);
  int missed = 0;
  // idle bus at time zero
  initial begin
    acc_o = 1'b0;
    acc_wr_o = 1'b0;
    from_primary_o = 1'b0;
    primary_addr_select_o = 7'h00;
    reg_addr_o = 8'h00;
    reg_wdata_o = 16'h0000;
  end
  // one whole addressed transfer; the request stands across the taking edge
  task automatic xfer(input logic wr, input logic prim, input logic [6:0] da, input logic [7:0] ra,
                      input logic [15:0] wd, output logic ack, output logic [15:0] rd);
    @(negedge clk_sys_i);
    acc_o = 1'b1;
    acc_wr_o = wr;
    from_primary_o = prim;
    primary_addr_select_o = da;
    reg_addr_o = ra;
    reg_wdata_o = wd;
    @(negedge clk_sys_i);
    ack = acc_ack_i;
    rd = reg_rdata_i;
    acc_o = 1'b0;
    reg_addr_o = ~ra; // released address and data lines never keep a stale value
    reg_wdata_o = ~wd;
  endtask : xfer
  // start-up registers only, defaults skipped, interface control last
  task automatic run_config(input int ofs_q[$], input int dat_q[$], input logic [15:0] ifc);
    logic ack;
    logic [15:0] rd;
    foreach (ofs_q[i]) begin
      if (dat_q[i] != 0) begin
        xfer(1'b1, 1'b0, 7'h1A, 8'(ofs_q[i]), 16'(dat_q[i]), ack, rd);
        if (ack !== 1'b1) missed++;
      end
    end
    xfer(1'b1, 1'b0, 7'h1A, 8'h06, ifc, ack, rd);
    if (ack !== 1'b1) missed++;
  endtask : run_config
endmodule : cfg_controller_model
`default_nettype wire

// [bench/test_dev_mode_startup_config.sv]
// self-checking bench for the development-mode start-up loader
`timescale 1ns/10ps
`default_nettype none
module test_dev_mode_startup_config;
  localparam int SLOT = 4;
  localparam int SETUP = 200;
  localparam int RUNIT = 3;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic power_on_req_i = 1'b0;
  logic acc_i, acc_wr_i, from_primary_i, acc_ack_o, prestart_indication_o, reset_n_o, alt_pin_select_o;
  logic [6:0] primary_addr_select_i, primary_addr_o;
  logic [7:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, rd;
  logic [2:0] power_state_o, debounce_period_o;
  logic [10:0] supply_en_o, exp_en;
  logic [27:0] converter_level_o;
  logic [19:0] regulator_level_o;
  logic [51:0] pin_function_o, fn;
  logic [12:0] pin_direction_o, pin_polarity_o, pin_pullup_o, pin_pulldown_o, pin_debounce_on_o;
  logic [6:0] paddr [4] = '{7'h1A, 7'h1B, 7'h1E, 7'h1F}; // 0x34/0x36/0x3C/0x3E in seven-bit form
  int bad_count = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h2A;
  int mem [int];
  int slot [11];
  int ofs_q [$];
  int dat_q [$];
  int k;
  logic ack;
  logic [1:0] sel;
  always #50 clk_sys_i = ~clk_sys_i;
  dev_mode_startup_config #(.SLOT_CYCLES(SLOT), .SETUP_CYCLES(SETUP), .RST_UNIT_CYCLES(RUNIT)) DUT (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .power_on_req_i(power_on_req_i), .acc_i(acc_i),
    .acc_wr_i(acc_wr_i), .from_primary_i(from_primary_i), .primary_addr_select_i(primary_addr_select_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .acc_ack_o(acc_ack_o), .reg_rdata_o(reg_rdata_o),
    .prestart_indication_o(prestart_indication_o), .reset_n_o(reset_n_o), .power_state_o(power_state_o),
    .supply_en_o(supply_en_o), .converter_level_o(converter_level_o), .regulator_level_o(regulator_level_o),
    .primary_addr_o(primary_addr_o), .alt_pin_select_o(alt_pin_select_o), .pin_function_o(pin_function_o),
    .pin_direction_o(pin_direction_o), .pin_polarity_o(pin_polarity_o), .pin_pullup_o(pin_pullup_o),
    .pin_pulldown_o(pin_pulldown_o), .pin_debounce_on_o(pin_debounce_on_o),
    .debounce_period_o(debounce_period_o));
  cfg_controller_model PARTNER (
    .clk_sys_i(clk_sys_i), .acc_ack_i(acc_ack_o), .reg_rdata_i(reg_rdata_o), .acc_o(acc_i),
    .acc_wr_o(acc_wr_i), .from_primary_o(from_primary_i), .primary_addr_select_o(primary_addr_select_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc
  task automatic put(input int ofs, input int dat);
    ofs_q.push_back(ofs);
    dat_q.push_back(dat);
    mem[ofs] = dat;
  endtask : put
  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #(100 * 3000);
    bad_count++;
    complete_run();
  end
  // main sequence
  initial begin
    cyc(5);
    rst_n_i = 1'b1;
    PARTNER.xfer(1'b0, 1'b0, 7'h1A, 8'h06, 16'h0000, ack, rd);
    chk({ack, rd, alt_pin_select_o, primary_addr_o}, {1'b1, 16'h8800, 1'b1, 7'h1A});
    PARTNER.xfer(1'b0, 1'b1, 7'h1A, 8'h06, 16'h0000, ack, rd);
    chk(ack, 1'b0);
    PARTNER.xfer(1'b0, 1'b0, 7'h1B, 8'h06, 16'h0000, ack, rd);
    chk(ack, 1'b0);
    // no done bit within the set-up window: back to off
    power_on_req_i = 1'b1;
    cyc(2);
    chk({prestart_indication_o, power_state_o, supply_en_o}, {1'b1, 3'h1, 11'h000});
    k = 2;
    while (power_state_o !== 3'h0 && k < SETUP + 10) begin
      cyc(1);
      k++;
    end
    chk(k, SETUP + 1);
    power_on_req_i = 1'b0;
    cyc(3);
    // random configuration; supply 2 never starts, supply 1 in the last slot
    for (int i = 0; i < 11; i++) begin
      slot[i] = (i == 1) ? 0 : (i == 0) ? 15 : int'(rnd() % 16);
      put(startup_cfg_pkg::OFS_TABLE[startup_cfg_pkg::SLOT_IDX[i]], slot[i] << 10);
    end
    for (int i = 0; i < 4; i++) begin
      put(startup_cfg_pkg::OFS_TABLE[startup_cfg_pkg::CONV_LVL_IDX[i]], int'(rnd() % 128));
      put(startup_cfg_pkg::OFS_TABLE[startup_cfg_pkg::REG_LVL_IDX[i]], int'(rnd() % 32));
    end
    for (int i = 2; i < 11; i++) put(startup_cfg_pkg::OFS_TABLE[i], int'(rnd() % ((i == 10) ? 16 : 65536)));
    put(8'h03, 2);
    sel = 2'(rnd());
    power_on_req_i = 1'b1;
    cyc(2);
    PARTNER.run_config(ofs_q, dat_q, 16'h1800 | (16'(sel) << 13));
    chk(PARTNER.missed, 0);
    chk({alt_pin_select_o, primary_addr_o, power_state_o}, {1'b0, paddr[sel], 3'h3});
    for (k = 1; k <= 80; k++) begin
      cyc(1);
      for (int i = 0; i < 11; i++) exp_en[i] = slot[i] != 0 && k >= 1 + (slot[i] - 1) * SLOT;
      chk(supply_en_o, exp_en);
      chk({reset_n_o, power_state_o}, (k < 15 * SLOT) ? {1'b0, 3'h3} :
          (k < 15 * SLOT + (mem[8'h03] + 1) * RUNIT) ? {1'b0, 3'h2} : {1'b1, 3'h6});
    end
    for (int i = 0; i < 4; i++) begin
      chk(converter_level_o[i*7 +: 7], mem[startup_cfg_pkg::OFS_TABLE[startup_cfg_pkg::CONV_LVL_IDX[i]]]);
      chk(regulator_level_o[i*5 +: 5], mem[startup_cfg_pkg::OFS_TABLE[startup_cfg_pkg::REG_LVL_IDX[i]]]);
    end
    fn = {4'(mem[8'h8F]), 16'(mem[8'h8E]), 16'(mem[8'h8D]), 16'(mem[8'h8C])};
    chk(pin_function_o, fn);
    chk({pin_pullup_o, pin_pulldown_o, pin_debounce_on_o, debounce_period_o},
        {13'(mem[8'h81]), 13'(mem[8'h82]), 13'(mem[8'h80]), 3'(mem[8'h80] >> 13)});
    chk({pin_direction_o, pin_polarity_o}, {13'(mem[8'h86]), 13'(mem[8'h87])});
    // after start-up: frozen slot write, refused pins, unmapped place, plain storage
    PARTNER.xfer(1'b1, 1'b1, paddr[sel], 8'hB7, 16'h0400, ack, rd);
    PARTNER.xfer(1'b0, 1'b1, paddr[sel], 8'hB7, 16'h0000, ack, rd);
    chk({ack, rd, supply_en_o[1]}, {1'b1, 16'h0000, 1'b0});
    PARTNER.xfer(1'b0, 1'b0, paddr[sel], 8'hB7, 16'h0000, ack, rd);
    chk(ack, 1'b0);
    PARTNER.xfer(1'b0, 1'b1, paddr[sel], 8'h10, 16'h0000, ack, rd);
    chk({ack, rd}, {1'b1, 16'h0000});
    PARTNER.xfer(1'b1, 1'b1, paddr[sel], 8'hA8, 16'hA5C3, ack, rd);
    PARTNER.xfer(1'b0, 1'b1, paddr[sel], 8'hA8, 16'h0000, ack, rd);
    chk({ack, rd}, {1'b1, 16'hA5C3});
    // host staggers supply enables one write at a time; they lie outside this block, so enables stay put
    for (int i = 0; i < 2; i++) begin
      PARTNER.xfer(1'b1, 1'b1, paddr[sel], (i == 0) ? 8'h0D : 8'hB0, 16'h0001, ack, rd);
      chk({ack, supply_en_o}, {1'b1, exp_en});
      cyc(10);
    end
    // power off with register reset selected
    power_on_req_i = 1'b0;
    cyc(2);
    chk({power_state_o, supply_en_o, prestart_indication_o, reset_n_o}, 16'h0000);
    PARTNER.xfer(1'b0, 1'b0, 7'h1A, 8'h06, 16'h0000, ack, rd);
    chk({ack, rd, alt_pin_select_o}, {1'b1, 16'h8800, 1'b1});
    complete_run();
  end
endmodule : test_dev_mode_startup_config
`default_nettype wire
